// ==== pkg/tilt_pkg.sv ====
// tilt sensor serial command port: shared constants
// assumes both ends and the bench compile this first
package tilt_pkg;
    localparam logic [7:0] normal_run_cmd = 8'h00;
    localparam logic [7:0] temperature_access_cmd = 8'h08;
    localparam logic [7:0] status_read_cmd = 8'h0a;
    localparam logic [7:0] nv_reload_cmd = 8'h0b;
    localparam logic [7:0] selftest_x_cmd = 8'h0e;
    localparam logic [7:0] selftest_y_cmd = 8'h0f;
    localparam logic [7:0] read_x_tilt_cmd = 8'h10;
    localparam logic [7:0] read_y_tilt_cmd = 8'h11;
    localparam int cmd_bits = 8;
    localparam int tilt_bits = 11;
    localparam int temp_bits = 8;
    localparam int status_bits = 8;
    // timing
    localparam int sys_period_ps = 25000;
    localparam int refresh_us = 150;
    localparam int refresh_cycles = (refresh_us * 1000000) / sys_period_ps;
    localparam int sck_max_khz = 500;
    // half period rounds up so the clock never exceeds the maximum
    localparam int sck_half_cycles =
        (1000000000 / (2 * sck_max_khz) + sys_period_ps - 1) / sys_period_ps;
    localparam int sample_rate_max = 5300;
    localparam int sample_gap_cycles =
        (1000000000 / sample_rate_max + (sys_period_ps / 1000) - 1)
        / (sys_period_ps / 1000);
    localparam logic [10:0] tilt_reset_value = 11'h400;
    localparam logic [7:0] temp_reset_value = 8'h00;
    localparam logic [7:0] status_reset_value = 8'h00;
endpackage

// ==== pkg/tilt_spi_if.sv ====
// serial link between microcontroller end and sensor end
// miso is resolved here from miso_oe_n, not by the bench
`timescale 1ns/1ps
interface tilt_spi_if;
    logic sck;
    logic chip_select_n;
    logic mosi;
    logic miso_o;
    logic miso_oe_n;
    logic miso;
    // a released line reads as the inverse of the last bit, so a stray
    // sample of it cannot pass for valid reply data
    assign miso = miso_oe_n ? !miso_o : miso_o;
    modport device (input sck, input chip_select_n, input mosi,
                    output miso_o, output miso_oe_n);
    modport master (output sck, output chip_select_n, output mosi,
                    input miso);
endinterface

// ==== sim/test_tilt_sensor_spi_command_port.sv ====
// testbench: master end and sensor end joined by the serial interface
// assumes the package, interface and both ends are compiled first
`timescale 1ns/1ps
module test_tilt_sensor_spi_command_port;
    localparam int refresh_sim = 20;
    localparam int gap_sim = 40;
    logic clk_sys_in = 1'b0;
    logic rstn_in = 1'b1;
    logic req_in = 1'b0;
    logic [7:0] cmd_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic busy_out;
    logic done_out;
    logic [10:0] rdata_out;
    logic [10:0] x_sample_in = 11'h5a3;
    logic [10:0] y_sample_in = 11'h401;
    logic [7:0] temp_sample_in = 8'h9e;
    logic [7:0] status_in = 8'h3c;
    logic selftest_x_out;
    logic selftest_y_out;
    logic nv_reload_out;
    logic [7:0] temp_written_out;
    logic [10:0] x_mid = 11'h5a3;
    logic [7:0] temp_mid = 8'h9e;
    int num_errors = 0;
    int checked = 0;
    int nv_pulses = 0;
    int cycles = 0;

    tilt_spi_if spi_bus();

    tilt_master_port #(.refresh_cycles(refresh_sim),
        .sample_gap_cycles(gap_sim)) i_tilt_master_port (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .spi(spi_bus),
        .req_in(req_in), .cmd_in(cmd_in), .wdata_in(wdata_in),
        .busy_out(busy_out), .done_out(done_out), .rdata_out(rdata_out));

    tilt_sensor_port #(.refresh_cycles(refresh_sim)) i_tilt_sensor_port (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .spi(spi_bus),
        .x_sample_in(x_sample_in), .y_sample_in(y_sample_in),
        .temp_sample_in(temp_sample_in), .status_in(status_in),
        .selftest_x_out(selftest_x_out), .selftest_y_out(selftest_y_out),
        .nv_reload_out(nv_reload_out), .temp_written_out(temp_written_out));

    tilt_port_asserts i_tilt_port_asserts (
        .clk_sys_in(clk_sys_in), .rstn_in(rstn_in), .sck(spi_bus.sck),
        .chip_select_n(spi_bus.chip_select_n), .mosi(spi_bus.mosi),
        .miso_o(spi_bus.miso_o), .miso_oe_n(spi_bus.miso_oe_n),
        .selftest_x_out(selftest_x_out), .selftest_y_out(selftest_y_out),
        .nv_reload_out(nv_reload_out));

    // -------------------------------------------------------------
    // clock, pulse monitor, hang guard
    // -------------------------------------------------------------
    always #12.5 clk_sys_in = ~clk_sys_in;

    always @(posedge clk_sys_in) begin
        if (nv_reload_out === 1'b1) begin
            nv_pulses++;
        end
    end

    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            report_and_stop();
        end
    end

    // -------------------------------------------------------------
    // tasks
    // -------------------------------------------------------------
    task automatic check(input logic [10:0] got, input logic [10:0] exp);
        checked++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one command frame; x and temperature samples change while the frame is open
    task automatic run_frame(input logic [7:0] cmd, input logic [7:0] wd);
        int n;
        n = 0;
        @(posedge clk_sys_in);
        #1;
        req_in = 1'b1;
        cmd_in = cmd;
        wdata_in = wd;
        while (busy_out !== 1'b1 && n < 2000) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        req_in = 1'b0;
        repeat (6) @(posedge clk_sys_in);
        #1;
        x_sample_in = x_mid;
        temp_sample_in = temp_mid;
        while (done_out !== 1'b1 && n < 6000) begin
            @(posedge clk_sys_in);
            #1;
            n++;
        end
        check({10'h000, done_out}, 11'h001);
        repeat (3) @(posedge clk_sys_in);
        #1;
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // -------------------------------------------------------------
    // test sequence
    // -------------------------------------------------------------
    initial begin
        // a true falling edge, so the link-clocked flops are reset too
        #1;
        rstn_in = 1'b0;
        repeat (4) @(posedge clk_sys_in);
        #1;
        rstn_in = 1'b1;
        repeat (60) @(posedge clk_sys_in);
        x_mid = 11'h1b4;
        run_frame(tilt_pkg::read_x_tilt_cmd, 8'h00);
        check(rdata_out, 11'h5a3);
        run_frame(tilt_pkg::read_y_tilt_cmd, 8'h00);
        check(rdata_out, 11'h401);
        run_frame(tilt_pkg::read_x_tilt_cmd, 8'h00);
        check(rdata_out, 11'h1b4);
        temp_mid = 8'h61;
        run_frame(tilt_pkg::temperature_access_cmd, 8'h5b);
        check(rdata_out, 11'h09e);
        check({3'h0, temp_written_out}, 11'h05b);
        run_frame(tilt_pkg::temperature_access_cmd, 8'h00);
        check(rdata_out, 11'h061);
        check({3'h0, temp_written_out}, 11'h000);
        run_frame(tilt_pkg::status_read_cmd, 8'h00);
        check(rdata_out, 11'h03c);
        run_frame(tilt_pkg::nv_reload_cmd, 8'h00);
        check(11'(nv_pulses), 11'h001);
        run_frame(tilt_pkg::selftest_x_cmd, 8'h00);
        check({9'h0, selftest_x_out, selftest_y_out}, 11'h002);
        run_frame(tilt_pkg::selftest_y_cmd, 8'h00);
        check({9'h0, selftest_x_out, selftest_y_out}, 11'h000);
        run_frame(tilt_pkg::selftest_y_cmd, 8'h00);
        check({9'h0, selftest_x_out, selftest_y_out}, 11'h001);
        run_frame(tilt_pkg::read_y_tilt_cmd, 8'h00);
        check({9'h0, selftest_x_out, selftest_y_out}, 11'h001);
        run_frame(tilt_pkg::normal_run_cmd, 8'h00);
        check({9'h0, selftest_x_out, selftest_y_out}, 11'h000);
        run_frame(8'h0c, 8'h00);
        run_frame(8'hff, 8'h00);
        check(11'(nv_pulses), 11'h001);
        run_frame(tilt_pkg::read_x_tilt_cmd, 8'h00);
        check(rdata_out, 11'h1b4);
        report_and_stop();
    end
endmodule // test_tilt_sensor_spi_command_port

// ==== sim/tilt_port_asserts.sv ====
// assertion checker for the tilt serial link between both ends
// assumes it sits beside the interface, all signals in the clk_sys_in domain
`timescale 1ns/1ps
module tilt_port_asserts (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    input wire logic sck,
    input wire logic chip_select_n,
    input wire logic mosi,
    input wire logic miso_o,
    input wire logic miso_oe_n,
    input wire logic selftest_x_out,
    input wire logic selftest_y_out,
    input wire logic nv_reload_out
);
    default clocking cb @(posedge clk_sys_in);
    endclocking
    default disable iff (!rstn_in);

    // -------------------------------------------------------------
    // helper logic: sck history, rising edge count, command capture
    // -------------------------------------------------------------
    logic sck_d_reg;
    logic [7:0] stable_reg;
    logic [4:0] rise_reg;
    logic [7:0] cmd_reg;
    logic rise;
    logic cmd_ok;
    logic reply_cmd;

    assign rise = sck && !sck_d_reg;
    assign reply_cmd = cmd_reg inside {tilt_pkg::temperature_access_cmd,
        tilt_pkg::status_read_cmd, tilt_pkg::read_x_tilt_cmd,
        tilt_pkg::read_y_tilt_cmd};
    assign cmd_ok = reply_cmd || cmd_reg inside {tilt_pkg::normal_run_cmd,
        tilt_pkg::nv_reload_cmd, tilt_pkg::selftest_x_cmd,
        tilt_pkg::selftest_y_cmd};

    // saturating count of samples since sck last changed
    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            sck_d_reg <= 1'b0;
            stable_reg <= 8'hff;
        end else begin
            sck_d_reg <= sck;
            if (sck != sck_d_reg) begin
                stable_reg <= 8'h00;
            end else if (stable_reg != 8'hff) begin
                stable_reg <= stable_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rise_reg <= 5'h00;
            cmd_reg <= 8'h00;
        end else if (chip_select_n) begin
            rise_reg <= 5'h00;
            cmd_reg <= 8'h00;
        end else if (rise) begin
            if (rise_reg != 5'h1f) begin
                rise_reg <= rise_reg + 5'h01;
            end
            if (rise_reg < 5'h08) begin
                cmd_reg <= {cmd_reg[6:0], mosi};
            end
        end
    end

    // -------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------
    a_idle_clock_low: assert property (chip_select_n |-> !sck)
        else $error("serial clock not low outside a frame");
    a_idle_miso_released: assert property (
        chip_select_n [*5] |-> miso_oe_n)
        else $error("miso driven while chip select high");
    a_sck_half_period: assert property (
        !chip_select_n && sck != sck_d_reg |-> stable_reg >= 8'h27)
        else $error("serial clock phase shorter than minimum");
    a_mosi_on_low: assert property (
        !chip_select_n && $changed(mosi) |-> !sck)
        else $error("mosi changed while serial clock high");
    a_miso_on_fall: assert property (
        !miso_oe_n && $stable(miso_oe_n) && $changed(miso_o) |-> !sck)
        else $error("miso changed while serial clock high");
    a_reply_first_bit: assert property (
        rise && rise_reg == 5'h08 && reply_cmd |-> !miso_oe_n)
        else $error("reply not driven after command byte");
    a_bad_cmd_quiet: assert property (
        !chip_select_n && !sck && rise_reg >= 5'h08 && !cmd_ok
        |-> miso_oe_n)
        else $error("miso driven after unknown command");
    a_selftest_exclusive: assert property (
        !(selftest_x_out && selftest_y_out))
        else $error("both self tests active");
    a_reload_pulse: assert property (
        nv_reload_out |=> !nv_reload_out)
        else $error("reload pulse longer than one cycle");

    c_long_read: cover property (rise && rise_reg == 5'h12);
    c_bad_cmd: cover property (rise_reg == 5'h08 && !cmd_ok);
    c_selftest_y: cover property ($rose(selftest_y_out));
endmodule // tilt_port_asserts

// ==== src/tilt_master_port.sv ====
// microcontroller end: runs one command frame per request
// assumes miso is resolved by the interface; sck made by a divider
`timescale 1ns/1ps
module tilt_master_port #(
    parameter int refresh_cycles = tilt_pkg::refresh_cycles,
    parameter int sample_gap_cycles = tilt_pkg::sample_gap_cycles
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    tilt_spi_if.master spi,
    input wire logic req_in,
    input wire logic [7:0] cmd_in,
    input wire logic [7:0] wdata_in,
    output logic busy_out,
    output logic done_out,
    output logic [10:0] rdata_out
);
    // ------------------------------------------------------------
    // frame sequencer
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        st_idle = 4'h1, st_low = 4'h2, st_high = 4'h4, st_end = 4'h8
    } state_t;
    state_t state_reg;
    logic miso_s;
    logic [7:0] div_reg;
    logic [4:0] bit_reg;
    logic [4:0] total_reg;
    logic [18:0] shift_out_reg;
    logic [10:0] shift_in_reg;
    logic [31:0] gap_reg;
    logic [31:0] need_reg;
    logic sck_reg;
    logic cs_reg;
    logic st_active_reg;
    logic [7:0] req_cmd;

    tilt_sync u_miso (.clk_in(clk_sys_in), .rstn_in(rstn_in),
        .d_in(spi.miso), .q_out(miso_s));

    function automatic logic [4:0] reply_len(input logic [7:0] c);
        if (c == tilt_pkg::read_x_tilt_cmd || c == tilt_pkg::read_y_tilt_cmd)
            return 5'(tilt_pkg::tilt_bits);
        if (c == tilt_pkg::temperature_access_cmd ||
            c == tilt_pkg::status_read_cmd)
            return 5'(tilt_pkg::temp_bits);
        return 5'd0;
    endfunction

    // refused: any self test command, either axis, while one is active; normal run is sent instead
    assign req_cmd = (st_active_reg && (cmd_in == tilt_pkg::selftest_x_cmd
        || cmd_in == tilt_pkg::selftest_y_cmd)) ? tilt_pkg::normal_run_cmd
        : cmd_in;

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= st_idle;
            div_reg <= '0;
            bit_reg <= '0;
            total_reg <= '0;
            shift_out_reg <= '0;
            shift_in_reg <= '0;
            sck_reg <= 1'b0;
            cs_reg <= 1'b1;
            gap_reg <= '0;
            need_reg <= '0;
            done_out <= 1'b0;
            rdata_out <= '0;
            st_active_reg <= 1'b0;
            busy_out <= 1'b0;
        end else begin
            done_out <= 1'b0;
            if (gap_reg != 32'hffffffff && cs_reg) begin
                gap_reg <= gap_reg + 32'd1;
            end
            unique case (state_reg)
                st_idle: begin
                    // wait out the longer of the refresh interval and the sample gap before every frame but the first after reset
                    if (req_in && gap_reg >= need_reg) begin
                        cs_reg <= 1'b0;
                        total_reg <= 5'(tilt_pkg::cmd_bits)
                            + reply_len(req_cmd);
                        shift_out_reg <= {req_cmd,
                            reply_len(req_cmd) == 5'(tilt_pkg::temp_bits)
                            ? wdata_in : 8'h00, 3'h0};
                        bit_reg <= '0;
                        div_reg <= '0;
                        // short replies land right-aligned over zeros
                        shift_in_reg <= '0;
                        busy_out <= 1'b1;
                        if (req_cmd == tilt_pkg::normal_run_cmd)
                            st_active_reg <= 1'b0;
                        if (req_cmd == tilt_pkg::selftest_x_cmd ||
                            req_cmd == tilt_pkg::selftest_y_cmd)
                            st_active_reg <= 1'b1;
                        state_reg <= st_low;
                    end
                end
                st_low: begin
                    if (div_reg == 8'(tilt_pkg::sck_half_cycles - 1)) begin
                        div_reg <= '0;
                        sck_reg <= 1'b1;
                        state_reg <= st_high;
                    end else begin
                        div_reg <= div_reg + 8'd1;
                    end
                end
                st_high: begin
                    if (div_reg == 8'(tilt_pkg::sck_half_cycles - 1)) begin
                        div_reg <= '0;
                        sck_reg <= 1'b0;
                        shift_out_reg <= {shift_out_reg[17:0], 1'b0};
                        if (bit_reg >= 5'(tilt_pkg::cmd_bits))
                            shift_in_reg <= {shift_in_reg[9:0], miso_s};
                        bit_reg <= bit_reg + 5'd1;
                        state_reg <= (bit_reg + 5'd1 == total_reg)
                            ? st_end : st_low;
                    end else begin
                        div_reg <= div_reg + 8'd1;
                    end
                end
                st_end: begin
                    if (div_reg == 8'(tilt_pkg::sck_half_cycles - 1)) begin
                        cs_reg <= 1'b1;
                        gap_reg <= '0;
                        need_reg <= (refresh_cycles > sample_gap_cycles)
                            ? refresh_cycles : sample_gap_cycles;
                        rdata_out <= shift_in_reg;
                        done_out <= 1'b1;
                        busy_out <= 1'b0;
                        state_reg <= st_idle;
                    end else begin
                        div_reg <= div_reg + 8'd1;
                    end
                end
                default: begin
                    state_reg <= st_idle;
                    busy_out <= 1'b0;
                end
            endcase
        end
    end

    assign spi.sck = sck_reg;
    assign spi.chip_select_n = cs_reg;
    assign spi.mosi = shift_out_reg[18];
endmodule // tilt_master_port

// ==== src/tilt_sensor_port.sv ====
// sensor end of the tilt serial command port
// assumes sck from the master is the link clock; samples come in on clk_sys_in
`timescale 1ns/1ps
module tilt_sensor_port #(
    parameter int refresh_cycles = tilt_pkg::refresh_cycles
) (
    input wire logic clk_sys_in,
    input wire logic rstn_in,
    tilt_spi_if.device spi,
    input wire logic [10:0] x_sample_in,
    input wire logic [10:0] y_sample_in,
    input wire logic [7:0] temp_sample_in,
    input wire logic [7:0] status_in,
    output logic selftest_x_out,
    output logic selftest_y_out,
    output logic nv_reload_out,
    output logic [7:0] temp_written_out
);
    // ------------------------------------------------------------
    // system side: refresh of data registers
    // ------------------------------------------------------------
    logic cs_sys;
    logic [10:0] x_hold_reg;
    logic [10:0] y_hold_reg;
    logic [7:0] temp_hold_reg;
    logic [7:0] status_hold_reg;
    logic [31:0] refresh_reg;

    tilt_sync #(.init(1'b1)) u_cs_sync (
        .clk_in(clk_sys_in),
        .rstn_in(rstn_in),
        .d_in(spi.chip_select_n),
        .q_out(cs_sys)
    );

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            refresh_reg <= '0;
            x_hold_reg <= tilt_pkg::tilt_reset_value;
            y_hold_reg <= tilt_pkg::tilt_reset_value;
            temp_hold_reg <= tilt_pkg::temp_reset_value;
            status_hold_reg <= tilt_pkg::status_reset_value;
        end else if (cs_sys) begin
            if (refresh_reg >= 32'(refresh_cycles - 1)) begin
                refresh_reg <= '0;
                x_hold_reg <= x_sample_in;
                y_hold_reg <= y_sample_in;
                temp_hold_reg <= temp_sample_in;
                status_hold_reg <= status_in;
            end else begin
                refresh_reg <= refresh_reg + 32'd1;
            end
        end
    end

    // ------------------------------------------------------------
    // link side: command decode and shifting
    // ------------------------------------------------------------
    // hold registers are stable while chip select is low, so sampling
    // them in the sck domain during a frame is safe
    logic [4:0] count_reg;
    logic [7:0] cmd_reg;
    logic [10:0] out_reg;
    logic [7:0] in_reg;
    logic bad_reg;
    logic active_reg;
    logic st_x_reg;
    logic st_y_reg;
    logic reload_tgl_reg;
    logic [7:0] temp_wr_reg;
    logic [7:0] cmd_next;

    function automatic logic known_cmd(input logic [7:0] c);
        return c == tilt_pkg::normal_run_cmd ||
            c == tilt_pkg::temperature_access_cmd ||
            c == tilt_pkg::status_read_cmd ||
            c == tilt_pkg::nv_reload_cmd ||
            c == tilt_pkg::selftest_x_cmd ||
            c == tilt_pkg::selftest_y_cmd ||
            c == tilt_pkg::read_x_tilt_cmd ||
            c == tilt_pkg::read_y_tilt_cmd;
    endfunction

    assign cmd_next = {cmd_reg[6:0], spi.mosi};

    // rising edge: capture, count, decode
    always_ff @(posedge spi.sck or posedge spi.chip_select_n) begin
        if (spi.chip_select_n) begin
            count_reg <= '0;
            cmd_reg <= '0;
            bad_reg <= 1'b0;
            in_reg <= '0;
        end else if (!bad_reg) begin
            if (count_reg < 5'(tilt_pkg::cmd_bits)) begin
                cmd_reg <= cmd_next;
                count_reg <= count_reg + 5'd1;
                if (count_reg == 5'(tilt_pkg::cmd_bits - 1)) begin
                    bad_reg <= !known_cmd(cmd_next);
                end
            end else if (count_reg < 5'd31) begin
                in_reg <= {in_reg[6:0], spi.mosi};
                count_reg <= count_reg + 5'd1;
            end
        end
    end

    // self test and reload, held across frames on the link clock
    always_ff @(posedge spi.sck or negedge rstn_in) begin
        if (!rstn_in) begin
            st_x_reg <= 1'b0;
            st_y_reg <= 1'b0;
            reload_tgl_reg <= 1'b0;
            temp_wr_reg <= '0;
        end else if (!spi.chip_select_n && !bad_reg) begin
            if (count_reg == 5'(tilt_pkg::cmd_bits - 1)) begin
                unique case (cmd_next)
                    tilt_pkg::normal_run_cmd: begin
                        st_x_reg <= 1'b0;
                        st_y_reg <= 1'b0;
                    end
                    tilt_pkg::selftest_x_cmd: st_x_reg <= 1'b1;
                    tilt_pkg::selftest_y_cmd: st_y_reg <= 1'b1;
                    tilt_pkg::nv_reload_cmd:
                        reload_tgl_reg <= !reload_tgl_reg;
                    default: ;
                endcase
            end else if (count_reg == 5'(tilt_pkg::cmd_bits
                         + tilt_pkg::temp_bits - 1) &&
                         cmd_reg == tilt_pkg::temperature_access_cmd) begin
                temp_wr_reg <= {in_reg[6:0], spi.mosi};
            end
        end
    end

    // falling edge: load reply after the command, then shift
    always_ff @(negedge spi.sck or posedge spi.chip_select_n) begin
        if (spi.chip_select_n) begin
            out_reg <= '0;
            active_reg <= 1'b0;
        end else if (count_reg == 5'(tilt_pkg::cmd_bits) && !active_reg
                     && !bad_reg) begin
            active_reg <= 1'b1;
            unique case (cmd_reg)
                tilt_pkg::read_x_tilt_cmd: out_reg <= x_hold_reg;
                tilt_pkg::read_y_tilt_cmd: out_reg <= y_hold_reg;
                tilt_pkg::temperature_access_cmd:
                    out_reg <= {temp_hold_reg, 3'h0};
                tilt_pkg::status_read_cmd:
                    out_reg <= {status_hold_reg, 3'h0};
                default: out_reg <= '0;
            endcase
        end else if (active_reg) begin
            out_reg <= {out_reg[9:0], 1'b0};
        end
    end

    assign spi.miso_o = out_reg[10];
    assign spi.miso_oe_n = !active_reg || bad_reg;

    // ------------------------------------------------------------
    // back to the system clock
    // ------------------------------------------------------------
    logic st_x_s;
    logic st_y_s;
    logic tgl_s;
    logic tgl_d_reg;
    logic reload_reg;
    logic [7:0] temp_out_reg;

    tilt_sync u_stx (.clk_in(clk_sys_in), .rstn_in(rstn_in),
        .d_in(st_x_reg), .q_out(st_x_s));
    tilt_sync u_sty (.clk_in(clk_sys_in), .rstn_in(rstn_in),
        .d_in(st_y_reg), .q_out(st_y_s));
    tilt_sync u_tgl (.clk_in(clk_sys_in), .rstn_in(rstn_in),
        .d_in(reload_tgl_reg), .q_out(tgl_s));

    always_ff @(posedge clk_sys_in or negedge rstn_in) begin
        if (!rstn_in) begin
            selftest_x_out <= 1'b0;
            selftest_y_out <= 1'b0;
            tgl_d_reg <= 1'b0;
            reload_reg <= 1'b0;
            temp_out_reg <= '0;
        end else begin
            selftest_x_out <= st_x_s;
            selftest_y_out <= st_y_s;
            tgl_d_reg <= tgl_s;
            reload_reg <= tgl_s ^ tgl_d_reg;
            // written value is stable once the frame has ended
            if (cs_sys) begin
                temp_out_reg <= temp_wr_reg;
            end
        end
    end
    assign nv_reload_out = reload_reg;
    assign temp_written_out = temp_out_reg;
endmodule // tilt_sensor_port

// ==== src/tilt_sync.sv ====
// two-flop synchroniser for a level
// assumes d_in comes from another clock domain
`timescale 1ns/1ps
module tilt_sync #(
    parameter logic init = 1'b0
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic d_in,
    output logic q_out
);
    logic meta_reg;
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            meta_reg <= init;
            q_out <= init;
        end else begin
            meta_reg <= d_in;
            q_out <= meta_reg;
        end
    end
endmodule // tilt_sync
